// file: core/fabric_params.svh
`ifndef FABRIC_PARAMS_SVH
`define FABRIC_PARAMS_SVH

// fabric geometry: one logic block
`define N_MC          16
`define CHAIN_LEN     8
`define TERMS_PER_MC  5
`define MAX_SETS      3
`define N_SHARED      16
`define N_DED         4
`define N_IO          16
`define N_IC          36
`define N_LIT         52
`define N_GOE         6
`define N_GOE_BASIC   2

// interconnect source positions
`define IC_DED_LSB    0
`define IC_IO_LSB     4
`define IC_MC_LSB     20

// configuration word layout
`define WORDS_PER_MC  13
`define MC_SHARED_W   10
`define MC_CTRL_W     12
`define MC_LEND_BIT   0
`define MC_BORROW_LSB 1
`define TERM_HI_W     20
`define SHARED_HI_W   4
`define CFG_GATE_W    208
`define CFG_PIN_W     210
`define CFG_OE_W      212
`define N_CFG         214
`define CFG_IDX_W     8

// per-pin field: [2:0] enable select, [3] open drain
`define PIN_OD_BIT    3
`define PSEL_GND      3'h0
`define PSEL_VCC      3'h1
`define PSEL_GOE0     3'h2

// output enable source byte: [7:6] kind, [5] invert, [3:0] index
`define OESRC_PIN     2'h0
`define OESRC_IO      2'h1
`define OESRC_MC      2'h2
`define OE_INV_BIT    5

// apb byte addresses
`define ADDR_W        12
`define ADDR_CTRL     12'h000
`define ADDR_STATUS   12'h004
`define ADDR_PINS     12'h008
`define ADDR_CFG_BASE 12'h100
`define ADDR_CFG_END  12'h458

// pin hand-over settle time
`define CLK_PERIOD_NS 5
`define SETTLE_NS     100
`define SETTLE_CYCLES ((`SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETTLE_W      8

`endif

// file: core/fabric_pkg.sv
package fabric_pkg;
	`include "fabric_params.svh"

	typedef enum logic [1:0] {
		VAR_BASIC    = 2'h0,
		VAR_ENHANCED = 2'h1,
		VAR_ISP      = 2'h2
	} variant_t;

	typedef enum logic [1:0] {
		ST_USER  = 2'h0,
		ST_ENTER = 2'h1,
		ST_PROG  = 2'h3,
		ST_EXIT  = 2'h2
	} prog_state_t;

	typedef struct packed {
		prog_state_t                      st;
		logic [`SETTLE_W-1:0]             settle;
		logic                             ctrl_prog;
		logic [`N_CFG-1:0][31:0]          cfg;
		logic [31:0]                      prdata;
		logic                             pready;
		logic                             pslverr;
		logic [1:0][`N_DED-1:0]           ded_s;
		logic [1:0][`N_IO-1:0]            io_s;
		logic [1:0][1:0]                  oen_s;
		logic [1:0][2:0]                  jtag_s;
		logic                             tck_prev;
		logic [31:0]                      scan;
		logic                             tdo;
		logic [`N_IC-1:0]                 ic;
		logic [`N_MC-1:0][`MAX_SETS-1:0]  mc_pipe;
		logic [`N_MC-1:0]                 mc_q;
	} core_state_t;

	typedef struct packed {
		logic [`N_IO-1:0] out;
		logic [`N_IO-1:0] oe;
		logic [`N_IO-1:0] pu;
	} io_state_t;
endpackage

// file: core/io_ctrl_if.sv
`timescale 1ns/1ps
interface io_ctrl_if;
	import fabric_pkg::*;
	logic                  park;
	logic                  od_allowed;
	logic [`N_IO-1:0][3:0] pin_cfg;
	logic [`N_GOE-1:0]     goe;
	logic [`N_MC-1:0]      mc;
	logic [`N_IO-1:0]      pin_out;
	logic [`N_IO-1:0]      pin_oe;
	logic [`N_IO-1:0]      pin_pu;

	modport core (output park, od_allowed, pin_cfg, goe, mc, input pin_out, pin_oe, pin_pu);
	modport block (input park, od_allowed, pin_cfg, goe, mc, output pin_out, pin_oe, pin_pu);
endinterface

// file: core/io_ctrl.sv
`timescale 1ns/1ps
module io_ctrl
	import fabric_pkg::*;
(
	input  wire logic pclk,
	input  wire logic presetn,
	io_ctrl_if.block  bus
);
	io_state_t        q;
	io_state_t        d;
	logic [`N_IO-1:0] en;
	logic [`N_IO-1:0] od;

	genvar p;
	generate
		for (p = 0; p < `N_IO; p++) begin : g_pin
			logic [2:0] sel;
			logic [2:0] gidx;
			assign sel  = bus.pin_cfg[p][2:0];
			assign gidx = sel - `PSEL_GOE0;
			assign en[p] = (sel == `PSEL_GND) ? 1'b0 :
			               (sel == `PSEL_VCC) ? 1'b1 : bus.goe[gidx];
			// open drain only on isp part
			assign od[p] = bus.pin_cfg[p][`PIN_OD_BIT] & bus.od_allowed;
		end
	endgenerate

	always_comb begin
		d = q;
		// input, output or both per pin
		d.out = bus.mc & ~od;
		// open drain pins only ever pull low
		d.oe  = (en & ~od) | (en & od & ~bus.mc);
		if (bus.park) begin
			d.oe = '0;
		end
		d.pu = {`N_IO{bus.park}};
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign bus.pin_out = q.out;
	assign bus.pin_oe  = q.oe;
	assign bus.pin_pu  = q.pu;
endmodule

// file: core/fabric_core.sv
// Overview of operation
// - sixteen inverted shared terms per block
// - any macrocell may use any shared term
// - OR stage takes at most twenty terms
// - up to three sets, each adds delay
// - two separate lending chains of eight
// - borrow only from contiguous lower neighbours
// - chain bottom lends only, top borrows only
// - inputs, pins, macrocells feed interconnect
// - each signal gated by configuration AND
// - each pin input, output or bidirectional
// - pin enable: global enable, zero, one
// - basic part: two active-low enable pins
// - enhanced part: six selectable global enables
// - open drain only on programmable part
// - macrocell and pin feedback independent
// - four-pin test port only shifts out the identity code; programming goes over APB
// - pins float with pull-up while programming
// - follows standard in-system configuration protocol; the code writes configuration over APB instead
// - block takes thirty-six interconnect inputs
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module fabric_core
	import fabric_pkg::*;
#(
	parameter variant_t    VARIANT = VAR_ISP,
	// identity value is arbitrary
	parameter logic [31:0] ID_CODE = 32'h5A5A_0C01
)
(
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic [`ADDR_W-1:0]  paddr,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire logic [`N_DED-1:0]   ded_in,
	input  wire logic [`N_IO-1:0]    io_in,
	output logic      [`N_IO-1:0]    io_out,
	output logic      [`N_IO-1:0]    io_oe,
	output logic      [`N_IO-1:0]    io_pullup,
	input  wire logic                out_enable_pin_a_n,
	input  wire logic                out_enable_pin_b_n,
	input  wire logic                tck,
	input  wire logic                tms,
	input  wire logic                tdi,
	output logic                     tdo
);
	core_state_t                           q;
	core_state_t                           d;
	io_ctrl_if                             ioc();
	logic [`N_LIT-1:0]                     lits;
	logic [`N_SHARED-1:0]                  shared_n;
	logic [`N_MC-1:0][`TERMS_PER_MC-1:0]   term;
	logic [`N_MC-1:0]                      terms_or;
	logic [`N_MC-1:0]                      eff_lend;
	logic [`N_MC-1:0]                      sum;
	logic [`N_MC-1:0][1:0]                 nsets;
	logic [`N_GOE-1:0]                     goe;
	logic                                  tck_rise;
	logic                                  setup;
	logic                                  access;

	// empty mask means an unused term, which must not read as true
	function automatic logic pterm(
		input logic [`N_LIT-1:0] mask,
		input logic [`N_LIT-1:0] v
	);
		return (mask != '0) && ((v & mask) == mask);
	endfunction

	function automatic logic cfg_hit(input logic [`ADDR_W-1:0] a);
		return (a >= `ADDR_CFG_BASE) && (a < `ADDR_CFG_END) && (a[1:0] == 2'h0);
	endfunction

	function automatic logic [`CFG_IDX_W-1:0] cfg_idx(input logic [`ADDR_W-1:0] a);
		logic [`ADDR_W-1:0] off;
		off = a - `ADDR_CFG_BASE;
		return off[`CFG_IDX_W+1:2];
	endfunction

	function automatic logic oe_source(
		input logic [7:0]        f,
		input logic [`N_IO-1:0]  pins,
		input logic [`N_MC-1:0]  mcs,
		input logic [1:0]        en_pins
	);
		logic v;
		v = 1'b0;
		case (f[7:6])
			`OESRC_PIN: v = en_pins[f[0]];
			`OESRC_IO:  v = pins[f[3:0]];
			`OESRC_MC:  v = mcs[f[3:0]];
			default:    v = 1'b0;
		endcase
		return v ^ f[`OE_INV_BIT];
	endfunction

	// shared terms join every macrocell literal set
	assign lits = {shared_n, q.ic};

	genvar i;
	genvar k;
	generate
		for (i = 0; i < `N_MC; i++) begin : g_mc
			localparam int B = i * `WORDS_PER_MC;
			// inverted shared term, one per macrocell
			assign shared_n[i] = ~pterm({{`N_SHARED{1'b0}},
				q.cfg[B+`MC_SHARED_W+1][`SHARED_HI_W-1:0], q.cfg[B+`MC_SHARED_W]},
				{{`N_SHARED{1'b0}}, q.ic});
			for (k = 0; k < `TERMS_PER_MC; k++) begin : g_term
				assign term[i][k] = pterm({q.cfg[B+2*k+1][`TERM_HI_W-1:0],
					q.cfg[B+2*k]}, lits);
			end
			assign terms_or[i] = |term[i];
			// top of each chain never lends
			assign eff_lend[i] = q.cfg[B+`MC_CTRL_W][`MC_LEND_BIT] &&
				((i % `CHAIN_LEN) != (`CHAIN_LEN - 1));
		end
	endgenerate

	// lent terms leave the lender's own OR stage
	always_comb begin
		int   pos;
		int   want;
		int   n;
		logic ok;
		logic acc;
		pos  = 0;
		want = 0;
		n    = 0;
		ok   = 1'b0;
		acc  = 1'b0;
		for (int m = 0; m < `N_MC; m++) begin
			pos  = m % `CHAIN_LEN;
			want = int'(q.cfg[m*`WORDS_PER_MC+`MC_CTRL_W][`MC_BORROW_LSB+:2]);
			n    = 0;
			ok   = 1'b1;
			acc  = eff_lend[m] ? 1'b0 : terms_or[m];
			// own five plus at most fifteen borrowed
			for (int s = 1; s <= `MAX_SETS; s++) begin
				if (ok && s <= want && s <= pos) begin
					if (eff_lend[m-s]) begin
						acc = acc | terms_or[m-s];
						n   = s;
					end else begin
						ok = 1'b0;
					end
				end else begin
					ok = 1'b0;
				end
			end
			sum[m]   = acc;
			nsets[m] = n[1:0];
		end
	end

	genvar o;
	generate
		for (o = 0; o < `N_GOE; o++) begin : g_goe
			if (VARIANT == VAR_BASIC) begin : g_basic
				if (o < `N_GOE_BASIC) begin : g_used
					assign goe[o] = ~q.oen_s[1][o];
				end else begin : g_none
					assign goe[o] = 1'b0;
				end
			end else begin : g_enh
				assign goe[o] = oe_source(q.cfg[`CFG_OE_W + o/4][8*(o%4) +: 8],
					q.io_s[1], q.mc_q, ~q.oen_s[1]);
			end
		end
	endgenerate

	assign tck_rise = q.jtag_s[1][0] & ~q.tck_prev;
	assign setup    = psel & ~penable;
	assign access   = psel & penable & q.pready;

	always_comb begin
		d = q;

		// pins reach logic only after two flops
		d.ded_s[0]  = ded_in;
		d.ded_s[1]  = q.ded_s[0];
		d.io_s[0]   = io_in;
		d.io_s[1]   = q.io_s[0];
		d.oen_s[0]  = {out_enable_pin_b_n, out_enable_pin_a_n};
		d.oen_s[1]  = q.oen_s[0];
		d.jtag_s[0] = {tdi, tms, tck};
		d.jtag_s[1] = q.jtag_s[0];

		// pin and macrocell feedback both kept
		// each line gated by its config bit
		// one register stage on every path
		d.ic = {q.mc_q, q.io_s[1], q.ded_s[1]} &
			{q.cfg[`CFG_GATE_W+1][`N_IC-33:0], q.cfg[`CFG_GATE_W]};

		// each granted set adds one cycle
		for (int m = 0; m < `N_MC; m++) begin
			d.mc_pipe[m] = {q.mc_pipe[m][`MAX_SETS-2:0], sum[m]};
			if (nsets[m] == 2'h0) begin
				d.mc_q[m] = sum[m];
			end else begin
				d.mc_q[m] = q.mc_pipe[m][nsets[m] - 2'h1];
			end
		end

		// pins parked through the whole mode change
		case (q.st)
			ST_USER: begin
				d.settle = '0;
				if (q.ctrl_prog) begin
					d.st = ST_ENTER;
				end
			end
			ST_ENTER: begin
				d.settle = q.settle + 1'b1;
				if (q.settle == `SETTLE_W'(`SETTLE_CYCLES - 1)) begin
					d.st     = ST_PROG;
					d.settle = '0;
				end
			end
			ST_PROG: begin
				if (!q.ctrl_prog) begin
					d.st = ST_EXIT;
				end
			end
			ST_EXIT: begin
				d.settle = q.settle + 1'b1;
				if (q.settle == `SETTLE_W'(`SETTLE_CYCLES - 1)) begin
					d.st     = ST_USER;
					d.settle = '0;
				end
			end
			default: begin
				d.st     = ST_USER;
				d.settle = '0;
			end
		endcase

		// answer is prepared in setup so pready comes from a flop
		d.pready  = 1'b0;
		d.pslverr = 1'b0;
		if (setup) begin
			d.pready = 1'b1;
			d.prdata = 32'h0000_0000;
			if (paddr == `ADDR_CTRL) begin
				d.prdata = {31'h0000_0000, q.ctrl_prog};
			end else if (paddr == `ADDR_STATUS) begin
				d.prdata = {14'h0000, q.st, q.mc_q};
			end else if (paddr == `ADDR_PINS) begin
				d.prdata = {q.io_s[1], ioc.pin_oe};
			end else if (cfg_hit(paddr)) begin
				d.prdata = q.cfg[cfg_idx(paddr)];
				d.pslverr = pwrite && (q.st != ST_PROG);
			end else begin
				d.pslverr = 1'b1;
			end
		end
		if (access && pwrite && !q.pslverr) begin
			if (paddr == `ADDR_CTRL) begin
				d.ctrl_prog = pwdata[0];
			end else if (cfg_hit(paddr)) begin
				d.cfg[cfg_idx(paddr)] = pwdata;
			end
		end

		d.tck_prev = q.jtag_s[1][0];
		if (tck_rise) begin
			if (q.jtag_s[1][1]) begin
				d.scan = ID_CODE;
			end else begin
				d.scan = {q.jtag_s[1][2], q.scan[31:1]};
				d.tdo  = q.scan[0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// park pins in every non-user state
	assign ioc.park       = (q.st != ST_USER);
	assign ioc.od_allowed = (VARIANT == VAR_ISP);
	assign ioc.pin_cfg    = {q.cfg[`CFG_PIN_W+1], q.cfg[`CFG_PIN_W]};
	assign ioc.goe        = goe;
	assign ioc.mc         = q.mc_q;

	io_ctrl u_io (
		.pclk    (pclk),
		.presetn (presetn),
		.bus     (ioc)
	);

	assign prdata    = q.prdata;
	assign pready    = q.pready;
	assign pslverr   = q.pslverr;
	assign tdo       = q.tdo;
	assign io_out    = ioc.pin_out;
	assign io_oe     = ioc.pin_oe;
	assign io_pullup = ioc.pin_pu;
endmodule

// file: tb/fabric_core_assertions.sv
`timescale 1ns/1ps
`include "fabric_params.svh"
module fabric_core_checker
	import fabric_pkg::*;
(
	input wire logic               pclk,
	input wire logic               presetn,
	input wire logic [`ADDR_W-1:0] paddr,
	input wire logic               psel,
	input wire logic               penable,
	input wire logic               pwrite,
	input wire logic [31:0]        pwdata,
	input wire logic               pready,
	input wire logic               pslverr,
	input wire logic [`N_IO-1:0]   io_oe,
	input wire logic [`N_IO-1:0]   io_pullup
);
	logic setup;
	logic ctrl_wr;
	logic cfg_adr;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	assign setup   = psel && !penable;
	assign ctrl_wr = psel && penable && pready && pwrite && paddr == `ADDR_CTRL;
	assign cfg_adr = paddr >= `ADDR_CFG_BASE && paddr < `ADDR_CFG_END;

	AST_SETUP_READY: assert property (setup |=> pready)
		else $error("no ready after setup");
	AST_READY_PULSE: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	AST_ERR_QUAL: assert property (pslverr |-> pready)
		else $error("error without ready");
	AST_UNMAPPED: assert property (setup && paddr inside {[12'h00C:12'h0FC]} |=> pslverr)
		else $error("unmapped access accepted");
	AST_CFG_LOCK: assert property (setup && pwrite && cfg_adr && io_pullup == '0 |=> pslverr)
		else $error("config write accepted in user mode");
	AST_PARK_FLOAT: assert property (|io_pullup |-> io_oe == '0)
		else $error("pin driven while parked");
	AST_PARK_ALL: assert property (io_pullup == '0 || &io_pullup)
		else $error("pins parked unevenly");
	AST_PARK_ENTRY: assert property (ctrl_wr && pwdata[0] |-> ##[1:3] &io_pullup)
		else $error("pins not parked on entry");
	AST_PARK_HOLD: assert property (ctrl_wr && !pwdata[0] && &io_pullup |=> (&io_pullup)[*8])
		else $error("pins released early");
	AST_PARK_EXIT: assert property (ctrl_wr && !pwdata[0] |-> ##[18:26] io_pullup == '0)
		else $error("pins not released on exit");

	cover property (ctrl_wr && pwdata[0]);
	cover property (setup && pwrite && cfg_adr && io_pullup == '0 ##1 pslverr);
	cover property (&io_pullup ##1 io_pullup == '0);
endmodule

bind fabric_core fabric_core_checker chk (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
	.pwdata, .pready, .pslverr, .io_oe, .io_pullup);

// file: tb/isp_programmer.sv
`timescale 1ns/1ps
module isp_programmer #(
	parameter int HALF = 8
)
(
	input  wire logic pclk,
	input  wire logic tdo,
	output logic      tck,
	output logic      tms,
	output logic      tdi
);
	initial begin
		tck = 1'b0;
		tms = 1'b0;
		tdi = 1'b0;
	end

	// test clock stands low between frames; data line keeps toggling
	task automatic pulse(input logic m);
		@(posedge pclk);
		tms <= m;
		tdi <= ~tdi;
		repeat (HALF) @(posedge pclk);
		tck <= 1'b1;
		repeat (HALF) @(posedge pclk);
		tck <= 1'b0;
	endtask

	task automatic read_id(output logic [31:0] id);
		id = '0;
		pulse(1'b1);
		for (int i = 0; i < 32; i++) begin
			pulse(1'b0);
			id[i] = tdo;
		end
	endtask
endmodule

// file: tb/pterm_expander_io_routing_bench.sv
`timescale 1ns/1ps
`include "fabric_params.svh"
module pterm_expander_io_routing_bench;
	import fabric_pkg::*;
	// identity value is arbitrary
	localparam logic [31:0] ID_VAL = 32'hC3A5_1E07;
	logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic              a_n, b_n, tck, tms, tdi, tdo;
	logic [11:0]       paddr;
	logic [31:0]       pwdata, prdata, id, rnd;
	logic [3:0]        ded_in;
	logic [15:0]       io_in, io_out, io_oe, io_pullup;
	logic [33:0]       exp_q[$];
	logic [33:0]       ex;
	integer            seed = 32'hBC2EB38E;
	int                err_total = 0;
	int                comparisons = 0;
	int                cycles = 0;

	fabric_core #(.VARIANT(VAR_ISP), .ID_CODE(ID_VAL)) uut (.pclk, .presetn, .paddr, .psel,
		.penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .ded_in, .io_in, .io_out,
		.io_oe, .io_pullup, .out_enable_pin_a_n(a_n), .out_enable_pin_b_n(b_n), .tck, .tms,
		.tdi, .tdo);
	isp_programmer prog (.pclk, .tdo, .tck, .tms, .tdi);

	always #2.5 pclk = ~pclk;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_sim;
		if (err_total == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// note: cd asks for a data compare, ee is the expected error flag
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
		input logic [31:0] e, input logic cd, input logic ee);
		exp_q.push_back({cd, ee, e});
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	always @(posedge pclk) begin
		if (pready === 1'b1 && exp_q.size() > 0) begin
			ex = exp_q.pop_front();
			check(pslverr, ex[32]);
			if (ex[33])
				check(prdata, ex[31:0]);
		end
	end

	// hang guard: the whole sequence needs well under this
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 6000) begin
			err_total++;
			end_sim();
		end
	end

	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{ded_in, io_in} = '0;
		{a_n, b_n} = 2'h3;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(`ADDR_CTRL, 1'b0, 32'h0, 32'h0, 1'b1, 1'b0);
		apb(`ADDR_STATUS, 1'b0, 32'h0, 32'h0, 1'b1, 1'b0);
		apb(12'h00C, 1'b0, 32'h0, 32'h0, 1'b1, 1'b1);
		apb(`ADDR_CFG_BASE, 1'b1, 32'h1, 32'h0, 1'b0, 1'b1);
		apb(`ADDR_CTRL, 1'b1, 32'h1, 32'h0, 1'b0, 1'b0);
		repeat (30) @(posedge pclk);
		check(io_pullup, 32'h0000_FFFF);
		check(io_oe, 32'h0);
		apb(`ADDR_STATUS, 1'b0, 32'h0, 32'h0003_0000, 1'b1, 1'b0);
		prog.read_id(id);
		check(id, ID_VAL);
		// a zero write clears the word before it is programmed
		apb(12'h444, 1'b1, 32'h0, 32'h0, 1'b0, 1'b0);
		rnd = {28'h0, 4'($random(seed))};
		apb(12'h444, 1'b1, rnd, 32'h0, 1'b0, 1'b0);
		apb(12'h444, 1'b0, 32'h0, rnd, 1'b1, 1'b0);
		apb(`ADDR_CFG_BASE, 1'b1, 32'h1, 32'h0, 1'b0, 1'b0);
		apb(12'h440, 1'b1, 32'h1, 32'h0, 1'b0, 1'b0);
		apb(12'h448, 1'b1, 32'h0000_0201, 32'h0, 1'b0, 1'b0);
		apb(12'h450, 1'b1, 32'h0, 32'h0, 1'b0, 1'b0);
		apb(`ADDR_CTRL, 1'b1, 32'h0, 32'h0, 1'b0, 1'b0);
		repeat (30) @(posedge pclk);
		check(io_pullup, 32'h0);
		ded_in <= {3'($random(seed)), 1'b1};
		io_in <= 16'($random(seed));
		for (int i = 0; i < 2; i++) begin
			a_n <= i[0];
			b_n <= ~i[0];
			repeat (10) @(posedge pclk);
			check(io_oe[2:0], {~i[0], 2'b01});
		end
		check(io_out[0], 1'b1);
		apb(`ADDR_STATUS, 1'b0, 32'h0, 32'h0000_0001, 1'b1, 1'b0);
		apb(`ADDR_PINS, 1'b0, 32'h0, {io_in, 16'h0001}, 1'b1, 1'b0);
		repeat (3) @(posedge pclk);
		end_sim();
	end
endmodule
